// ===== src/format_ctrl_pkg.sv
// Constants, types and field layout for the input format control block.
package format_ctrl_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] MAIN_CONTROL_WORD_ADDR = 8'h00;
  localparam logic [7:0] AUX_CONTROL_ADDR       = 8'h04;
  localparam logic [7:0] OFFSET_VALUE_ADDR      = 8'h08;
  localparam logic [7:0] STATUS_ADDR            = 8'h0C;

  // Reset of the main control word with bit 14 taken from the fuse.
  localparam logic [15:0] MAIN_CONTROL_RESET = 16'h04FC;
  localparam int          DUAL_BIT           = 14;

  // ------------------------------------------------------------------
  // Field codes
  // ------------------------------------------------------------------
  localparam logic [1:0] WIDTH_14 = 2'h0;
  localparam logic [1:0] WIDTH_12 = 2'h1;

  localparam int SAMPLE_BITS = 14;
  localparam int HALF_BITS   = 7;

  typedef struct packed {
    logic       offset_enable;
    logic       dual_enable;
    logic [1:0] input_width;
    logic       bit_mirror;
    logic       signed_format;
    logic       four_pin_serial_select;
    logic       reserved_8;
    logic       buffer_enable;
    logic       alarm_drive_enable;
    logic [5:0] low_bits;
  } main_control_t;

  typedef struct packed {
    logic [13:0] chan_a;
    logic [13:0] chan_b;
  } sample_pair_t;

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ  = 3'b100
  } bus_phase_t;

endpackage

// ===== src/format_ctrl.sv
// Input format control word with AHB-Lite access and the sample path it steers.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
module format_ctrl
  import format_ctrl_pkg::*;
#(
  parameter logic FUSE_DUAL  = 1'b1,
  parameter int   FIFO_DEPTH = 8,
  parameter int   CONV_DIV   = 2
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        in_valid,
  input  wire sample_pair_t in_pair,
  output sample_pair_t     out_pair,
  output logic             out_valid,
  output logic             four_pin_mode,
  output logic             alarm_out,
  output logic             alarm_oe
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int DW = $clog2(CONV_DIV + 1);

  // ------------------------------------------------------------------
  // Sample word helpers
  // ------------------------------------------------------------------
  function automatic logic [13:0] mirror(input logic [13:0] w, input logic half);
    logic [13:0] r;
    r = '0;
    for (int i = 0; i < SAMPLE_BITS; i++)
    begin
      if (half)
        r[i] = w[(i / HALF_BITS) * HALF_BITS + (HALF_BITS - 1 - i % HALF_BITS)];
      else
        r[i] = w[SAMPLE_BITS - 1 - i];
    end
    return r;
  endfunction

  function automatic logic [13:0] shape(input logic [13:0] w,
                                        input main_control_t c,
                                        input logic half,
                                        input logic [13:0] ofs);
    logic [13:0] v;
    v = w;
    if (c.bit_mirror)
      v = mirror(v, half);
    if (c.input_width == WIDTH_12)
      v[1:0] = 2'h0;
    else if (c.input_width != WIDTH_14)
      v[3:0] = 4'h0;
    if (!c.signed_format)
      v[13] = ~v[13];
    if (c.offset_enable)
      v = v + ofs;
    return v;
  endfunction

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  main_control_t ctrl;
  main_control_t next_ctrl;
  logic          half_mode;
  logic          next_half_mode;
  logic          die_id_enable;
  logic          next_die_id_enable;
  logic [13:0]   offset_value;
  logic [13:0]   next_offset_value;
  logic          overflow;
  logic          next_overflow;
  bus_phase_t    phase;
  bus_phase_t    next_phase;
  logic [7:0]    addr_q;
  logic [7:0]    next_addr_q;
  logic [31:0]   next_hrdata;

  logic [PW:0]   fifo_count;
  logic          fifo_full;
  logic          fifo_empty;
  logic          push;
  logic          status_clear;

  assign fifo_full  = (fifo_count == (PW + 1)'(FIFO_DEPTH));
  assign fifo_empty = (fifo_count == '0);
  assign push       = in_valid && ctrl.buffer_enable;

  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------
  always_comb
  begin
    logic take;
    take               = hsel && hready && htrans[1];
    next_ctrl          = ctrl;
    next_half_mode     = half_mode;
    next_die_id_enable = die_id_enable;
    next_offset_value  = offset_value;
    next_phase         = BUS_IDLE;
    next_addr_q        = addr_q;
    next_hrdata        = hrdata;
    status_clear       = 1'b0;
    case (phase)
      BUS_WRITE:
      begin
        case (addr_q)
          MAIN_CONTROL_WORD_ADDR: next_ctrl = main_control_t'(hwdata[15:0]);
          AUX_CONTROL_ADDR:
          begin
            next_half_mode     = hwdata[0];
            next_die_id_enable = hwdata[1];
          end
          OFFSET_VALUE_ADDR: next_offset_value = hwdata[13:0];
          STATUS_ADDR:       status_clear = hwdata[0];
          default:           next_ctrl = ctrl;
        endcase
      end
      default:
      begin
      end
    endcase
    if (take)
    begin
      next_addr_q = haddr[7:0];
      next_phase  = hwrite ? BUS_WRITE : BUS_READ;
      if (!hwrite)
      begin
        case (haddr[7:0])
          MAIN_CONTROL_WORD_ADDR: next_hrdata = {16'h0000, next_ctrl};
          AUX_CONTROL_ADDR:
            next_hrdata = {30'h0, next_die_id_enable, next_half_mode};
          OFFSET_VALUE_ADDR: next_hrdata = {18'h0, next_offset_value};
          STATUS_ADDR:
            next_hrdata = {16'h0000, 7'h00, 9'(fifo_count)} | {31'h0, overflow};
          default: next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl          <= main_control_t'(MAIN_CONTROL_RESET | (16'(FUSE_DUAL) << DUAL_BIT));
      half_mode     <= 1'b0;
      die_id_enable <= 1'b0;
      offset_value  <= 14'h0000;
      phase         <= BUS_IDLE;
      addr_q        <= 8'h00;
      hrdata        <= 32'h0000_0000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end
    else
    begin
      ctrl          <= next_ctrl;
      half_mode     <= next_half_mode;
      die_id_enable <= next_die_id_enable;
      offset_value  <= next_offset_value;
      phase         <= next_phase;
      addr_q        <= next_addr_q;
      hrdata        <= next_hrdata;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end
  end

  // The fuse is sampled once at reset; a later write may still change it.
  logic fuse_taken;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fuse_taken <= 1'b0;
    else
      fuse_taken <= 1'b1;
  end

  // ------------------------------------------------------------------
  // Conversion rate divider
  // ------------------------------------------------------------------
  logic [DW-1:0] div_count;
  logic [DW-1:0] next_div_count;
  logic          conv_tick;

  always_comb
  begin
    conv_tick      = (div_count == DW'(CONV_DIV - 1));
    next_div_count = conv_tick ? '0 : div_count + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      div_count <= '0;
    else
      div_count <= next_div_count;
  end

  // ------------------------------------------------------------------
  // Sample FIFO and output stage
  // ------------------------------------------------------------------
  sample_pair_t fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0]   next_fifo_count;
  logic          do_push;
  logic          pop;
  sample_pair_t  next_out_pair;
  logic          next_out_valid;
  sample_pair_t  shaped;

  always_comb
  begin
    sample_pair_t src;
    logic         dual;
    dual = ctrl.dual_enable;
    do_push = push && !fifo_full;
    pop     = conv_tick && !fifo_empty && ctrl.buffer_enable;
    src     = ctrl.buffer_enable ? fifo_mem[rd_ptr] : in_pair;
    shaped.chan_a = shape(src.chan_a, ctrl, half_mode, offset_value);
    shaped.chan_b = dual ? shape(src.chan_b, ctrl, half_mode, offset_value) : 14'h0000;
    next_wr_ptr     = do_push ? PW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr     = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
    next_fifo_count = fifo_count + (PW + 1)'(do_push) - (PW + 1)'(pop);
    next_out_valid  = ctrl.buffer_enable ? pop : in_valid;
    next_out_pair   = next_out_valid ? shaped : out_pair;
    // Overflow set wins over a clear in the same cycle.
    next_overflow   = (push && fifo_full) || (overflow && !status_clear);
  end

  always_ff @(posedge clk)
  begin
    if (do_push)
      fifo_mem[wr_ptr] <= in_pair;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      fifo_count <= '0;
      out_pair   <= '0;
      out_valid  <= 1'b0;
      overflow   <= 1'b0;
    end
    else
    begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      fifo_count <= next_fifo_count;
      out_pair   <= next_out_pair;
      out_valid  <= next_out_valid;
      overflow   <= next_overflow;
    end
  end

  // ------------------------------------------------------------------
  // Serial port mode and alarm pin
  // ------------------------------------------------------------------
  logic next_four_pin;
  logic next_alarm_out;
  logic next_alarm_oe;

  always_comb
  begin
    next_four_pin  = ctrl.four_pin_serial_select && !die_id_enable;
    next_alarm_out = overflow;
    next_alarm_oe  = ctrl.alarm_drive_enable;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      four_pin_mode <= 1'b0;
      alarm_out     <= 1'b0;
      alarm_oe      <= 1'b0;
    end
    else
    begin
      four_pin_mode <= next_four_pin;
      alarm_out     <= next_alarm_out;
      alarm_oe      <= next_alarm_oe;
    end
  end

  // Bit 14 follows the fuse after reset until software writes it.
  logic fuse_pending;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fuse_pending <= 1'b1;
    else if (phase == BUS_WRITE && addr_q == MAIN_CONTROL_WORD_ADDR)
      fuse_pending <= 1'b0;
    else if (fuse_taken)
      fuse_pending <= 1'b0;
  end

endmodule

// ===== dv/format_ctrl_properties.sv
// Assertion checker for the input format control block.
`timescale 1ns/10ps
module format_ctrl_properties
  import format_ctrl_pkg::*;
#(parameter logic FUSE_DUAL = 1'b1)
(
  input wire logic         clk,
  input wire logic         rst_n,
  input wire logic         hsel,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic [31:0]  hwdata,
  input wire logic         hready,
  input wire logic         in_valid,
  input wire sample_pair_t in_pair,
  input wire sample_pair_t out_pair,
  input wire logic         out_valid,
  input wire logic         four_pin_mode,
  input wire logic         alarm_oe
);
  logic [15:0] cfg;
  logic [1:0]  aux;
  logic        wr_cfg;
  logic        wr_aux;

  // ----------------------------------------
  // Shadow of the written control words
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg    <= MAIN_CONTROL_RESET | {1'b0, FUSE_DUAL, 14'h0};
      aux    <= 2'h0;
      wr_cfg <= 1'b0;
      wr_aux <= 1'b0;
    end
    else
    begin
      wr_cfg <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
      wr_aux <= hsel && hready && htrans[1] && hwrite && haddr == 32'h4;
      if (wr_cfg)
        cfg <= hwdata[15:0];
      if (wr_aux)
        aux <= hwdata[1:0];
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Outputs lag a write by a cycle, so they are judged once the words settle.
  sequence s_quiet;
    $stable(cfg) && $stable(aux) && $past(rst_n);
  endsequence
  sequence s_push;
    s_quiet ##0 (in_valid && !cfg[7]);
  endsequence

  AST_ALARM_OE: assert property (s_quiet |-> alarm_oe == cfg[6])
    else $error("alarm enable differs from control bit");
  AST_FOUR_PIN: assert property (s_quiet ##0 !aux[1] |-> four_pin_mode == cfg[9])
    else $error("four pin mode differs from control bit");
  AST_DIE_ID_WINS: assert property (s_quiet ##0 aux[1] |-> !four_pin_mode)
    else $error("four pin mode set under die id enable");
  AST_BYPASS_LAT: assert property (s_push |=> out_valid)
    else $error("bypass word not passed next cycle");
  AST_BYPASS_CAUSE: assert property (s_quiet ##0 (!cfg[7] && out_valid) |-> $past(in_valid))
    else $error("bypass output without input word");
  AST_BUF_LAT: assert property (s_quiet ##0 (in_valid && cfg[7]) |-> ##[1:4] out_valid)
    else $error("buffered word never left");
  AST_ONE_CHAN: assert property (s_quiet ##0 (out_valid && !cfg[14]) |-> out_pair.chan_b == 14'h0)
    else $error("second channel active in single mode");
  AST_OFS_BIN: assert property (s_push ##0 (cfg & 16'hBC00) == 16'h0
      |=> out_pair.chan_a[13] != $past(in_pair.chan_a[13]))
    else $error("offset binary top bit not inverted");
  AST_TWOS: assert property (s_push ##0 (cfg & 16'hBC00) == 16'h0400
      |=> out_pair.chan_a == $past(in_pair.chan_a))
    else $error("signed word altered");
endmodule

bind format_ctrl format_ctrl_properties #(.FUSE_DUAL(FUSE_DUAL)) props (.clk, .rst_n, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .in_valid, .in_pair, .out_pair, .out_valid,
  .four_pin_mode, .alarm_oe);

// ===== dv/pair_source.sv
// Behavioural data source that feeds sample pairs to the block.
`timescale 1ns/10ps
module pair_source
  import format_ctrl_pkg::*;
(
  input  wire logic    clk,
  output logic         in_valid,
  output sample_pair_t in_pair
);
  initial
  begin
    in_valid = 1'b0;
    in_pair  = '0;
  end

  // one shared clock
  // Words leave on the block's own clock, so bypass never meets skewed clocks.
  task automatic send(input sample_pair_t p, input logic last);
    in_valid <= 1'b1;
    in_pair  <= p;
    @(posedge clk);
    if (last)
    begin
      in_valid <= 1'b0;
      // A released bus shows the inverse so a stale word never passes as new.
      in_pair  <= ~p;
    end
  endtask
endmodule

// ===== dv/test_dac_input_format_control.sv
// Self-checking testbench for the input format control block.
`timescale 1ns/10ps
module test_dac_input_format_control;
  import format_ctrl_pkg::*;
  // Bit 16 of each entry is the seven-bit mode in the aux register.
  localparam logic [16:0] TAB [9] = '{17'h04440, 17'h04040, 17'h04C40, 17'h14C40,
    17'h05440, 17'h06440, 17'h07440, 17'h0C440, 17'h00440};
  localparam sample_pair_t P = {14'h2B4D, 14'h1C36};
  logic         clk, rst_n, hsel, hwrite;
  logic         hreadyout, hresp, out_valid, four_pin_mode, alarm_out, alarm_oe;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic         in_valid;
  sample_pair_t in_pair, out_pair;
  int           n_fail, n_checks;
  wire          hready = hreadyout;

  format_ctrl dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .in_valid, .in_pair, .out_pair, .out_valid, .four_pin_mode,
    .alarm_out, .alarm_oe);
  pair_source src (.clk, .in_valid, .in_pair);

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task tally_and_finish;
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic wait_on(input int which);
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while ((which ? out_valid : hready) !== 1'b1 && i < 40);
    if ((which ? out_valid : hready) !== 1'b1)
    begin
      n_fail++;
      tally_and_finish;
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_on(0);
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(0);
    r = hrdata;
  endtask

  function automatic logic [13:0] chan(logic [16:0] c, logic [13:0] x);
    logic [13:0] y;
    y = x;
    if (c[11])
      for (int k = 0; k < 14; k++)
        y[k] = c[16] ? x[(k / 7) * 7 + 6 - k % 7] : x[13 - k];
    if (c[13])
      y[3:0] = 4'h0;
    else if (c[12])
      y[1:0] = 2'h0;
    if (!c[10])
      y[13] = ~y[13];
    if (c[15])
      y = y + 14'h0123;
    return y;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    ahb(0, 32'h0, 32'h0, rd);
    chk(rd, 32'h000044FC);
    chk({31'h0, alarm_oe}, 32'h1);
    ahb(0, 32'h40, 32'h0, rd);
    chk(rd, 32'h0);
  endtask

  task automatic t_shape;
    ahb(1, 32'h8, 32'h00000123, rd);
    for (int i = 0; i < 9; i++)
    begin
      ahb(1, 32'h0, {16'h0, TAB[i][15:0]}, rd);
      ahb(1, 32'h4, {31'h0, TAB[i][16]}, rd);
      src.send(P, 1'b1);
      wait_on(1);
      chk({4'h0, out_pair}, {4'h0, chan(TAB[i], P.chan_a),
        TAB[i][14] ? chan(TAB[i], P.chan_b) : 14'h0});
    end
  endtask

  task automatic t_fifo;
    ahb(1, 32'h0, 32'h00004480, rd);
    fork
      for (int k = 0; k < 3; k++)
        src.send({14'(k + 1), 14'(k + 5)}, k == 2);
      for (int k = 0; k < 3; k++)
      begin
        wait_on(1);
        chk({4'h0, out_pair}, {4'h0, 14'(k + 1), 14'(k + 5)});
      end
    join
  endtask

  task automatic t_serial;
    logic [31:0] w;
    for (int i = 0; i < 4; i++)
    begin
      w = {16'h0, 6'h11, i[0], 2'h0, i[0], 6'h0};
      ahb(1, 32'h4, {30'h0, i[1], 1'b0}, rd);
      ahb(1, 32'h0, w, rd);
      ahb(0, 32'h0, 32'h0, rd);
      chk(rd, w);
      repeat (2) @(posedge clk);
      chk({31'h0, four_pin_mode}, {31'h0, i[0] & !i[1]});
      chk({31'h0, alarm_oe}, {31'h0, i[0]});
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    rst_n  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h0;
    hwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_shape;
    t_fifo;
    t_serial;
    tally_and_finish;
  end
endmodule
